//--- testbench/shi_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
module shi_link_sva (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       req,
  input wire logic       we,
  input wire logic       chan,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       intack,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       int_req,
  input wire logic [1:0] wait_rdy_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] base_q;  // last base vector sent to channel b
  logic       sav_q;   // channel b copy of status affects vector
  logic [1:0] hs_q;    // handshake enable per channel
  logic [1:0] hs_go;   // handshake enable write in flight
  assign hs_go = (req && we && !intack && addr == 4'h1 && wdata[7]) ? {chan, !chan} : 2'b00;
  // shadow configuration, updated when the write is answered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_q <= 8'h00;
      sav_q  <= 1'b0;
      hs_q   <= 2'b00;
    end else if (ack && we && !intack) begin
      if (chan && addr == 4'h2) base_q <= wdata;
      if (chan && addr == 4'h1) sav_q <= wdata[2];
      if (addr == 4'h1) hs_q[chan] <= wdata[7];
    end
  end
  sequence take_s;
    req && !ack && (&wait_rdy_n);
  endsequence
  sequence ans_s;
    ack ##1 !req;
  endsequence
  take_answer_a: assert property (take_s |=> ans_s)
    else $error("link access not answered");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> req && $past(req))
    else $error("ack without request");
  rdata_hold_a: assert property ($changed(rdata) |-> ack)
    else $error("read data moved outside ack");
  req_hold_a: assert property (req && !ack |=> req && $stable({we, chan, addr, wdata}))
    else $error("request dropped before ack");
  vec_base_a: assert property (intack && ack && !sav_q |-> rdata == base_q)
    else $error("unmodified vector wrong");
  vec_none_a: assert property (intack && ack && sav_q && !$past(int_req)
    |-> rdata == {base_q[7:4], shi_pkg::VC_NONE, base_q[0]})
    else $error("idle vector wrong");
  hs_off_a: assert property ((wait_rdy_n | hs_q | hs_go) == 2'b11)
    else $error("handshake active while disabled");
endmodule // shi_link_sva
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  logic            clk_sys, rst, hsel, hwrite, hreadyout, hresp;
  logic [1:0]      htrans, rx_valid, rx_par, tx_take, brk, cts_n, dcd_n;
  logic [31:0]     haddr, hwdata, hrdata, r;
  logic [1:0][7:0] rx_char, txc, fmt;
  logic [1:0]      tx_valid, rts_n, dtr_n, rx_en, undr;
  logic [7:0]      v;
  int              failures, comparisons;
  shi_link_if lnk ();
  shi_device_end shi_device_end_inst (.clk_sys, .rst, .lnk(lnk), .rx_valid, .rx_char,
    .rx_par_err(rx_par), .rx_eof(2'b00), .tx_take, .tx_underrun(undr), .brk_det(brk),
    .cts_n, .dcd_n, .sync_n(2'b11), .tx_valid, .tx_char(txc), .rts_n, .dtr_n,
    .rx_enable(rx_en), .line_format(fmt));
  shi_host_end shi_host_end_inst (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .lnk(lnk));
  shi_link_sva shi_link_sva_inst (.clk_sys, .rst, .req(lnk.req), .we(lnk.we),
    .chan(lnk.chan), .addr(lnk.addr), .wdata(lnk.wdata), .intack(lnk.intack),
    .ack(lnk.ack), .rdata(lnk.rdata), .int_req(lnk.int_req), .wait_rdy_n(lnk.wait_rdy_n));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // one single word transfer, data phase value left in r
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // link access through the host, polled until no longer busy
  task automatic op(input logic [15:0] o);
    int n = 0;
    ahb(1'b1, 8'h00, {16'h0, o});
    do begin ahb(1'b0, 8'h04, 32'h0); n++; end while (r[8] !== 1'b0 && n < 40);
    if (r[8] !== 1'b0) failures++;
    v = r[7:0];
  endtask
  task automatic wr(input logic c, input logic [3:0] a, input logic [7:0] d);
    op({3'b001, c, a, d});
  endtask
  task automatic rd(input logic c, input logic [3:0] a); op({3'b000, c, a, 8'h00}); endtask
  task automatic ia(input logic [7:0] e); op(16'h4000); `CHK("vector", e, v) endtask
  task automatic rx(input int c, input logic p, input logic [7:0] d);
    rx_char[c] <= d; rx_par[c] <= p; rx_valid[c] <= 1'b1;
    @(posedge clk_sys) rx_valid[c] <= 1'b0;
  endtask
  task automatic take(input int c); tx_take[c] <= 1'b1; @(posedge clk_sys) tx_take[c] <= 1'b0;
  endtask
  task automatic t_order;
    wr(1'b0, 4'h1, 8'h00);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK("order error", 1'b1, r[shi_pkg::ST_ERR])
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK("order clear", 1'b0, r[shi_pkg::ST_ERR])
    wr(1'b0, 4'h4, 8'h44);
    `CHK("line format", 8'h44, fmt[0])
    wr(1'b1, 4'h4, 8'h44);
  endtask
  task automatic t_tx;
    wr(1'b0, 4'h3, 8'h21);
    wr(1'b0, 4'h8, 8'h41);
    `CHK("tx char", 8'h41, txc[0])
    `CHK("tx before enable", 1'b0, tx_valid[0])
    wr(1'b0, 4'h5, 8'h08);
    `CHK("modem outputs", 2'b00, {rts_n[0], dtr_n[0]})
    `CHK("tx held by cts", 1'b0, tx_valid[0])
    cts_n[0] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("tx after cts", 1'b1, tx_valid[0])
    take(0);
    rd(1'b0, 4'h0);
    `CHK("tx empty", 1'b1, v[2])
    ahb(1'b1, 8'h08, 32'h2);
    cts_n[0] <= 1'b1;
    wr(1'b0, 4'h3, 8'h21);
    wr(1'b0, 4'h8, 8'h42);
    `CHK("cts general", 2'b11, {tx_valid[0], rx_en[0]})
  endtask
  task automatic t_vec;
    wr(1'b1, 4'h2, 8'hf0);
    wr(1'b1, 4'h1, 8'h1f);
    wr(1'b0, 4'h1, 8'h1b);
    wr(1'b0, 4'h0, 8'h10);
    wr(1'b1, 4'h0, 8'h10);
    take(0);
    rx(1, 1'b0, 8'h5a);
    ia(8'hf8);
    wr(1'b0, 4'h0, 8'h28);
    ia(8'hf4);
    rd(1'b1, 4'h0);
    `CHK("rx available", 1'b1, v[0])
    dcd_n[1] <= 1'b0;
    ia(8'hf4);
    rd(1'b1, 4'h8);
    `CHK("rx data", 8'h5a, v)
    ia(8'hf2);
    wr(1'b1, 4'h0, 8'h10);
    ia(8'hf6);
  endtask
  task automatic t_rxm;
    wr(1'b0, 4'h1, 8'h10);
    rx(0, 1'b1, 8'h33);
    ia(8'hfe);
    rd(1'b0, 4'h0);
    `CHK("special shows rx", 1'b1, v[0])
    wr(1'b0, 4'h0, 8'h30);
    rd(1'b0, 4'h8);
    wr(1'b0, 4'h1, 8'h08);
    wr(1'b0, 4'h0, 8'h20);
    rx(0, 1'b0, 8'h34);
    ia(8'hfc);
    rd(1'b0, 4'h8);
    rx(0, 1'b1, 8'h35);
    ia(8'hf6);
    rx(0, 1'b0, 8'h36);
    ia(8'hfe);
    wr(1'b0, 4'h1, 8'h00);
    wr(1'b0, 4'h0, 8'h30);
    rx(0, 1'b0, 8'h37);
    ia(8'hf6);
    rd(1'b0, 4'h8);
  endtask
  task automatic t_brk;
    brk[1] <= 1'b1;
    ia(8'hf2);
    wr(1'b1, 4'h0, 8'h10);
    brk[1] <= 1'b0;
    ia(8'hf2);
    wr(1'b1, 4'h0, 8'h10);
    undr[1] <= 1'b1;
    ia(8'hf2);
    undr[1] <= 1'b0;
    wr(1'b1, 4'h0, 8'h10);
    ia(8'hf6);
  endtask
  task automatic t_hs;
    wr(1'b0, 4'h1, 8'hc0);
    take(0);
    `CHK("ready on empty", 1'b0, lnk.wait_rdy_n[0])
    wr(1'b0, 4'h8, 8'h50);
    `CHK("ready when full", 1'b1, lnk.wait_rdy_n[0])
    wr(1'b0, 4'h1, 8'h80);
    fork
      wr(1'b0, 4'h8, 8'h51);
      begin
        repeat (14) @(posedge clk_sys);
        `CHK("wait while full", 1'b0, lnk.wait_rdy_n[0])
        take(0);
      end
    join
  endtask
  task automatic t_poll;
    ahb(1'b1, 8'h08, 32'h1);
    wr(1'b1, 4'h1, 8'h1b);
    rx(1, 1'b0, 8'h11);
    rd(1'b1, 4'h0);
    `CHK("polled rx status", 1'b1, v[0])
    ahb(1'b0, 8'h04, 32'h0);
    `CHK("polled no interrupt", 1'b0, r[shi_pkg::ST_INT])
  endtask
  task automatic complete_run;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung handshake ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    complete_run;
  end
  initial begin
    rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    rx_valid = 2'b00; rx_par = 2'b00; rx_char = '0; tx_take = 2'b00; brk = 2'b00;
    cts_n = 2'b11; dcd_n = 2'b11; undr = 2'b00;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_order;
    t_tx;
    t_vec;
    t_rxm;
    t_brk;
    t_hs;
    t_poll;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire

//--- verilog/shi_device_end.sv
`timescale 1ns/1ns
`default_nettype none
module shi_device_end (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  shi_link_if.dev              lnk,
  input  wire logic [1:0]      rx_valid,
  input  wire logic [1:0][7:0] rx_char,
  input  wire logic [1:0]      rx_par_err,
  input  wire logic [1:0]      rx_eof,
  input  wire logic [1:0]      tx_take,
  input  wire logic [1:0]      tx_underrun,
  input  wire logic [1:0]      brk_det,
  input  wire logic [1:0]      cts_n,
  input  wire logic [1:0]      dcd_n,
  input  wire logic [1:0]      sync_n,
  output logic      [1:0]      tx_valid,
  output logic      [1:0][7:0] tx_char,
  output logic      [1:0]      rts_n,
  output logic      [1:0]      dtr_n,
  output logic      [1:0]      rx_enable,
  output logic      [1:0][7:0] line_format
);
  // per channel configuration, channel B alone owns the vector
  logic [1:0][7:0] itm;
  logic [1:0][7:0] rxp;
  logic [1:0][7:0] cps;
  logic [1:0][7:0] txp;
  logic [7:0]      bvec;
  // per channel data and flags
  logic [1:0][7:0] rx_buf;
  logic [1:0]      rx_avail, err_par, err_ovr, err_eof, armed;
  logic [1:0]      tx_empty, tx_ip, ext_ip, rx_ip, sp_ip;
  logic [1:0]      cts_q, dcd_q, sync_q, brk_q, undr_lat;
  // link answer flops
  logic            ack_q;
  logic [7:0]      rdata_q;
  // access decode
  logic            acc, hold;
  logic [1:0]      can, dat_acc, rd_dat, wr_dat, wr_cmd, wr_cfg;
  logic [2:0]      cmd;
  logic [1:0]      ovr_ev, spc_ev, rxc_ev, ext_ev;
  logic [2:0]      vcode;
  logic [7:0]      vector;

  assign cmd = lnk.wdata[shi_pkg::CMD_LO+:3];

  // per channel strobes and events
  always_comb begin
    hold = 1'b0;
    for (int c = 0; c < shi_pkg::NCH; c++) begin
      logic [1:0] rxm;
      rxm = itm[c][shi_pkg::ITM_RXM+:2];
      can[c] = itm[c][shi_pkg::ITM_WR_RX] ? rx_avail[c] : tx_empty[c];
      dat_acc[c] = lnk.req && !lnk.intack && (lnk.chan == c[0])
                   && (lnk.addr == shi_pkg::A_DATA);
      if (dat_acc[c] && itm[c][shi_pkg::ITM_WR_EN] && !itm[c][shi_pkg::ITM_WR_FN]
          && !can[c]) begin
        hold = 1'b1;
      end
      rd_dat[c] = 1'b0;
      wr_dat[c] = 1'b0;
      wr_cmd[c] = 1'b0;
      wr_cfg[c] = 1'b0;
      if (lnk.req && !ack_q && !lnk.intack && (lnk.chan == c[0])) begin
        rd_dat[c] = !lnk.we && (lnk.addr == shi_pkg::A_DATA);
        wr_dat[c] = lnk.we && (lnk.addr == shi_pkg::A_DATA);
        wr_cmd[c] = lnk.we && (lnk.addr == shi_pkg::A_CMD);
        wr_cfg[c] = lnk.we;
      end
      // a new char landing on an unread one is an overrun
      ovr_ev[c] = rx_valid[c] && rx_avail[c] && !rd_dat[c];
      // specials need first or every mode
      // parity is no special in first mode
      spc_ev[c] = rx_valid[c]
                  && (ovr_ev[c] || rx_eof[c]
                      || (rx_par_err[c] && rxm == shi_pkg::RXM_ALL_PV))
                  && ((rxm == shi_pkg::RXM_ALL) || (rxm == shi_pkg::RXM_ALL_PV)
                      || ((rxm == shi_pkg::RXM_FIRST) && !armed[c]));
      rxc_ev[c] = rx_valid[c] && !spc_ev[c]
                  && ((rxm == shi_pkg::RXM_ALL) || (rxm == shi_pkg::RXM_ALL_PV)
                      || ((rxm == shi_pkg::RXM_FIRST) && armed[c]));
      ext_ev[c] = itm[c][shi_pkg::ITM_EXT_IE]
                  && ((cts_n[c] ^ cts_q[c]) || (dcd_n[c] ^ dcd_q[c])
                      || (sync_n[c] ^ sync_q[c]) || (brk_det[c] ^ brk_q[c])
                      || (tx_underrun[c] && !undr_lat[c]));
    end
  end

  // waits hold the access open; the strobes above ignore hold, their register updates gate on acc except the overrun check on rd_dat
  assign acc = lnk.req && !ack_q && !hold;

  // fixed priority scan
  // lowest first so a higher source overwrites the code
  always_comb begin
    vcode = shi_pkg::VC_NONE;
    for (int c = shi_pkg::NCH - 1; c >= 0; c--) begin
      if (ext_ip[c]) vcode = {c == 0, shi_pkg::VK_EXT};
      if (tx_ip[c]) vcode = {c == 0, shi_pkg::VK_TX};
      if (rx_ip[c]) vcode = {c == 0, shi_pkg::VK_RX};
      if (sp_ip[c]) vcode = {c == 0, shi_pkg::VK_SP};
    end
  end

  // status affects vector in channel B
  assign vector = itm[1][shi_pkg::ITM_SAV] ? {bvec[7:4], vcode, bvec[0]} : bvec;

  assign lnk.int_req = |{sp_ip, rx_ip, tx_ip, ext_ip};
  assign lnk.ack = ack_q;
  assign lnk.rdata = rdata_q;

  // handshake pins and serial side outputs
  always_comb begin
    for (int c = 0; c < shi_pkg::NCH; c++) begin
      // wait or ready by mode bits
      lnk.wait_rdy_n[c] = !(itm[c][shi_pkg::ITM_WR_EN]
                            && (itm[c][shi_pkg::ITM_WR_FN] ? can[c]
                                : (dat_acc[c] && !can[c])));
      tx_valid[c] = !tx_empty[c] && txp[c][shi_pkg::TXP_TXEN]
                    && (!rxp[c][shi_pkg::RXP_AUTO] || !cts_n[c]);
      rts_n[c] = !txp[c][shi_pkg::TXP_RTS];
      dtr_n[c] = !txp[c][shi_pkg::TXP_DTR];
      rx_enable[c] = rxp[c][shi_pkg::RXP_EN];
      line_format[c] = cps[c];
    end
  end

  // configuration writes, order is the host's duty
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      itm <= '0;
      rxp <= '0;
      cps <= '0;
      txp <= '0;
      bvec <= shi_pkg::RST_REG;
    end else if (acc) begin
      for (int c = 0; c < shi_pkg::NCH; c++) begin
        if (wr_cfg[c]) begin
          case (lnk.addr)
            shi_pkg::A_ITM: itm[c] <= lnk.wdata;
            shi_pkg::A_RXP: rxp[c] <= lnk.wdata;
            shi_pkg::A_CPS: cps[c] <= lnk.wdata;
            shi_pkg::A_TXP: txp[c] <= lnk.wdata;
            shi_pkg::A_BVEC: begin
              // the vector lives in channel B only
              if (c == 1) bvec <= lnk.wdata;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // receive side, each channel on its own
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_buf <= '0;
      rx_avail <= '0;
      err_par <= '0;
      err_ovr <= '0;
      err_eof <= '0;
      armed <= '1;
      rx_ip <= '0;
      sp_ip <= '0;
    end else begin
      for (int c = 0; c < shi_pkg::NCH; c++) begin
        // clears first, so a same-cycle event below wins
        if (rd_dat[c] && acc) begin
          rx_avail[c] <= 1'b0;
          rx_ip[c] <= 1'b0;
        end
        if (wr_cmd[c] && acc && cmd == shi_pkg::CMD_ERR_RST) begin
          err_par[c] <= 1'b0;
          err_ovr[c] <= 1'b0;
          err_eof[c] <= 1'b0;
          sp_ip[c] <= 1'b0;
        end
        if (wr_cmd[c] && acc && cmd == shi_pkg::CMD_ARM_FIRST) armed[c] <= 1'b1;
        if (rx_valid[c]) begin
          rx_buf[c] <= rx_char[c];
          rx_avail[c] <= 1'b1;
          if (rx_par_err[c]) err_par[c] <= 1'b1;
          if (ovr_ev[c]) err_ovr[c] <= 1'b1;
          if (rx_eof[c]) err_eof[c] <= 1'b1;
          if (itm[c][shi_pkg::ITM_RXM+:2] == shi_pkg::RXM_FIRST) armed[c] <= 1'b0;
        end
        if (rxc_ev[c]) rx_ip[c] <= 1'b1;
        if (spc_ev[c]) sp_ip[c] <= 1'b1;
      end
    end
  end

  // transmit side: buffer empty flag and its interrupt
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_empty <= '1;
      tx_ip <= '0;
      tx_char <= '0;
    end else begin
      for (int c = 0; c < shi_pkg::NCH; c++) begin
        if (wr_dat[c] && acc) begin
          tx_char[c] <= lnk.wdata;
          tx_empty[c] <= 1'b0;
          tx_ip[c] <= 1'b0;
        end else if (tx_take[c] && tx_valid[c]) begin
          tx_empty[c] <= 1'b1;
          if (itm[c][shi_pkg::ITM_TX_IE]) tx_ip[c] <= 1'b1;
        end
        if (wr_cmd[c] && acc && cmd == shi_pkg::CMD_RST_TXIP
            && !(tx_take[c] && tx_valid[c])) begin
          tx_ip[c] <= 1'b0;
        end
      end
    end
  end

  // external status: pin snapshots, break level, underrun latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cts_q <= '1;
      dcd_q <= '1;
      sync_q <= '1;
      brk_q <= '0;
      undr_lat <= '0;
      ext_ip <= '0;
    end else begin
      cts_q <= cts_n;
      dcd_q <= dcd_n;
      sync_q <= sync_n;
      brk_q <= brk_det;
      for (int c = 0; c < shi_pkg::NCH; c++) begin
        if (wr_cmd[c] && acc && cmd == shi_pkg::CMD_RST_EXT) begin
          ext_ip[c] <= 1'b0;
          undr_lat[c] <= 1'b0;
        end
        if (tx_underrun[c]) undr_lat[c] <= 1'b1;
        if (ext_ev[c]) ext_ip[c] <= 1'b1;
      end
    end
  end

  // link answer, one cycle after the access is taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= acc;
      if (acc && lnk.intack) begin
        rdata_q <= vector;
      end else if (acc && !lnk.we) begin
        case (lnk.addr)
          // rx at bit 0, tx at bit 2
          shi_pkg::A_CMD: rdata_q <= {brk_q[lnk.chan], undr_lat[lnk.chan], !cts_n[lnk.chan],
                             !sync_n[lnk.chan], !dcd_n[lnk.chan], tx_empty[lnk.chan],
                             !lnk.chan && lnk.int_req,
                             rx_avail[lnk.chan] || err_par[lnk.chan]
                             || err_ovr[lnk.chan] || err_eof[lnk.chan]};
          shi_pkg::A_ITM: rdata_q <= {err_eof[lnk.chan], 1'b0, err_ovr[lnk.chan],
                             err_par[lnk.chan], 4'h0};
          shi_pkg::A_BVEC: rdata_q <= vector;
          shi_pkg::A_DATA: rdata_q <= rx_buf[lnk.chan];
          default: rdata_q <= '0;
        endcase
      end
    end
  end
endmodule // shi_device_end
`default_nettype wire

//--- verilog/shi_host_end.sv
`timescale 1ns/1ns
`default_nettype none
module shi_host_end (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  shi_link_if.host         lnk
);
  shi_pkg::shi_hstate_t state;      // sequencer state
  logic                 ap_wr;      // write data phase pending
  logic [7:0]           ap_addr;    // latched byte address
  logic [1:0]           ctrl;       // polled and cts-general modes
  logic [1:0]           cps_done;   // format written per channel
  logic                 order_err;  // sticky refused-write flag
  logic [7:0]           last_rd;    // last read or vector answer from the device
  logic                 start, refuse;
  logic [7:0]           next_wdata; // write byte after host fixes
  logic                 op_chan, op_wr;
  logic [3:0]           op_addr;

  // zero wait states; only whole-word singles are expected
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign op_chan = hwdata[shi_pkg::OP_CHAN];
  assign op_wr = hwdata[shi_pkg::OP_WR];
  assign op_addr = hwdata[shi_pkg::OP_ADDR+:4];
  assign start = ap_wr && (ap_addr == shi_pkg::H_OP) && (state == shi_pkg::SHI_IDLE);

  // host-side policing of the byte that goes out
  always_comb begin
    next_wdata = hwdata[7:0];
    refuse = 1'b0;
    if (op_wr && !hwdata[shi_pkg::OP_IACK]) begin
      if ((op_addr == shi_pkg::A_ITM || op_addr == shi_pkg::A_RXP
           || op_addr == shi_pkg::A_TXP) && !cps_done[op_chan]) begin
        refuse = 1'b1;
      end
      if (op_addr == shi_pkg::A_ITM && ctrl[shi_pkg::CT_POLL]) begin
        next_wdata[shi_pkg::ITM_EXT_IE] = 1'b0;
        next_wdata[shi_pkg::ITM_TX_IE] = 1'b0;
        next_wdata[shi_pkg::ITM_RXM+:2] = shi_pkg::RXM_OFF;
      end
      if (op_addr == shi_pkg::A_RXP && ctrl[shi_pkg::CT_CTSG]) begin
        next_wdata[shi_pkg::RXP_AUTO] = 1'b0;
      end
      if (op_addr == shi_pkg::A_TXP && hwdata[shi_pkg::TXP_TXEN]) begin
        next_wdata[shi_pkg::TXP_RTS] = 1'b1;
        next_wdata[shi_pkg::TXP_DTR] = 1'b1;
      end
    end
  end

  // ahb address phase capture and read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ap_wr <= 1'b0;
      ap_addr <= '0;
      hrdata <= '0;
    end else begin
      ap_wr <= hsel && hready && htrans[1] && hwrite;
      ap_addr <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          shi_pkg::H_STAT: hrdata <= {19'h0, order_err, lnk.wait_rdy_n, lnk.int_req,
                                      state == shi_pkg::SHI_BUSY, last_rd};
          shi_pkg::H_CTRL: hrdata <= {30'h0, ctrl};
          default: hrdata <= '0;
        endcase
      end
    end
  end

  // control register and sticky error
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
      order_err <= 1'b0;
      cps_done <= '0;
    end else begin
      if (ap_wr && ap_addr == shi_pkg::H_CTRL) begin
        ctrl <= hwdata[1:0];
        order_err <= 1'b0;
      end
      // a refusal on the same edge wins over the clear
      if (start && refuse) order_err <= 1'b1;
      if (start && op_wr && op_addr == shi_pkg::A_CPS) cps_done[op_chan] <= 1'b1;
    end
  end

  // link sequencer: hold the access until the device answers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= shi_pkg::SHI_IDLE;
      lnk.req <= 1'b0;
      lnk.we <= 1'b0;
      lnk.chan <= 1'b0;
      lnk.addr <= '0;
      lnk.wdata <= '0;
      lnk.intack <= 1'b0;
      last_rd <= '0;
    end else begin
      case (state)
        shi_pkg::SHI_IDLE: begin
          if (start && !refuse) begin
            state <= shi_pkg::SHI_BUSY;
            lnk.req <= 1'b1;
            lnk.we <= op_wr && !hwdata[shi_pkg::OP_IACK];
            lnk.chan <= op_chan;
            lnk.addr <= op_addr;
            lnk.wdata <= next_wdata;
            lnk.intack <= hwdata[shi_pkg::OP_IACK];
          end
        end
        shi_pkg::SHI_BUSY: begin
          if (lnk.ack) begin
            state <= shi_pkg::SHI_IDLE;
            lnk.req <= 1'b0;
            if (!lnk.we) last_rd <= lnk.rdata;
          end
        end
        default: state <= shi_pkg::SHI_IDLE;
      endcase
    end
  end
endmodule // shi_host_end
`default_nettype wire

//--- verilog/shi_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// parallel bus between the controlling host and the serial controller
interface shi_link_if;
  logic            req;        // access held until ack
  logic            we;         // write when high
  logic            chan;       // 0 channel A, 1 channel B
  logic [3:0]      addr;       // register index
  logic [7:0]      wdata;      // write data
  logic            intack;     // interrupt acknowledge access
  logic            ack;        // one-cycle end of access
  logic [7:0]      rdata;      // read data or vector, valid with ack
  logic            int_req;    // level, any pending interrupt
  logic [1:0]      wait_rdy_n; // per channel handshake, active low
  modport dev  (input req, we, chan, addr, wdata, intack,
                output ack, rdata, int_req, wait_rdy_n);
  modport host (output req, we, chan, addr, wdata, intack,
                input ack, rdata, int_req, wait_rdy_n);
endinterface
`default_nettype wire

//--- verilog/shi_pkg.sv
`default_nettype none
package shi_pkg;
  // number of serial channels, index 0 is channel A, index 1 is channel B
  localparam int unsigned NCH = 2;
  // device register indices on the link (writes / reads)
  localparam logic [3:0] A_CMD  = 4'h0; // write: command, read: main_status_reg
  localparam logic [3:0] A_ITM  = 4'h1; // write: int_transfer_mode_reg, read: special_rx_status_reg
  localparam logic [3:0] A_BVEC = 4'h2; // write: base_vector_reg, read: vector_readback_reg
  localparam logic [3:0] A_RXP  = 4'h3; // rx_param_reg
  localparam logic [3:0] A_CPS  = 4'h4; // clock_parity_stop_reg
  localparam logic [3:0] A_TXP  = 4'h5; // tx_param_reg
  localparam logic [3:0] A_DATA = 4'h8; // rx buffer read, tx buffer write
  // int_transfer_mode_reg fields
  localparam int unsigned ITM_EXT_IE = 0;
  localparam int unsigned ITM_TX_IE  = 1;
  localparam int unsigned ITM_SAV    = 2;
  localparam int unsigned ITM_RXM    = 3; // two bits, 4:3
  localparam int unsigned ITM_WR_RX  = 5; // handshake follows receiver
  localparam int unsigned ITM_WR_FN  = 6; // 0 wait, 1 ready
  localparam int unsigned ITM_WR_EN  = 7;
  // receive interrupt modes
  localparam logic [1:0] RXM_OFF    = 2'h0;
  localparam logic [1:0] RXM_FIRST  = 2'h1;
  localparam logic [1:0] RXM_ALL_PV = 2'h2; // every char, parity modifies vector
  localparam logic [1:0] RXM_ALL    = 2'h3;
  // rx_param_reg / tx_param_reg fields
  localparam int unsigned RXP_EN   = 0;
  localparam int unsigned RXP_AUTO = 5;
  localparam int unsigned TXP_RTS  = 1;
  localparam int unsigned TXP_TXEN = 3;
  localparam int unsigned TXP_DTR  = 7;
  // command field, bits 5:3 of a command write
  localparam int unsigned CMD_LO        = 3;
  localparam logic [2:0]  CMD_RST_EXT   = 3'h2;
  localparam logic [2:0]  CMD_ARM_FIRST = 3'h4;
  localparam logic [2:0]  CMD_RST_TXIP  = 3'h5;
  localparam logic [2:0]  CMD_ERR_RST   = 3'h6;
  // main_status_reg / special_rx_status_reg bits
  localparam int unsigned MS_RXAV = 0;
  localparam int unsigned MS_INTP = 1;
  localparam int unsigned MS_TXE  = 2;
  localparam int unsigned MS_DCD  = 3;
  localparam int unsigned MS_SYNC = 4;
  localparam int unsigned MS_CTS  = 5;
  localparam int unsigned MS_UNDR = 6;
  localparam int unsigned MS_BRK  = 7;
  localparam int unsigned SR_PAR  = 4;
  localparam int unsigned SR_OVR  = 5;
  localparam int unsigned SR_EOF  = 7;
  // vector modification: {channel A, kind} replaces vector bits 3:1
  localparam logic [1:0] VK_TX   = 2'h0;
  localparam logic [1:0] VK_EXT  = 2'h1;
  localparam logic [1:0] VK_RX   = 2'h2;
  localparam logic [1:0] VK_SP   = 2'h3;
  localparam logic [2:0] VC_NONE = 3'h3;
  localparam logic [7:0] RST_REG = 8'h00;
  // host register map on AHB-Lite (byte addresses)
  localparam logic [7:0] H_OP   = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam logic [7:0] H_CTRL = 8'h08;
  localparam int unsigned OP_ADDR = 8;  // four bits, 11:8
  localparam int unsigned OP_CHAN = 12;
  localparam int unsigned OP_WR   = 13;
  localparam int unsigned OP_IACK = 14;
  localparam int unsigned ST_BUSY = 8;
  localparam int unsigned ST_INT  = 9;
  localparam int unsigned ST_WAIT = 10; // two bits, 11:10
  localparam int unsigned ST_ERR  = 12;
  localparam int unsigned CT_POLL = 0;
  localparam int unsigned CT_CTSG = 1;
  // host sequencer states
  typedef enum logic [1:0] {
    SHI_IDLE = 2'b01,
    SHI_BUSY = 2'b10
  } shi_hstate_t;
endpackage
`default_nettype wire
